/* File: hw/pbwr_buffer_ctrl.sv */
`timescale 1ns/100ps
module pbwr_buffer_ctrl (
  input wire logic sys_clk, // 100 MHz clock
  input wire logic srst, // sync reset, active high
  input wire logic [11:0] paddr, // apb address
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped
  input wire logic buffer_load_sequence_step, // load step active
  input wire logic buffer_load_substep, // write sub-step
  input wire logic instruction_kind_select, // low: print-and-load
  input wire logic revolution_count_low, // revolution count bit 0
  input wire logic revolution_count_high, // revolution count bit 1
  input wire logic marker_h, // first-revolution marker
  input wire logic marker_i, // second-revolution marker
  input wire logic marker_j, // third-revolution marker
  input wire logic t0b, // word-time pulse t0B
  input wire logic t4b, // word-time pulse t4B
  input wire logic t11b, // word-time pulse t11B
  input wire logic print_active, // print reading phase
  input wire logic line_end, // end-of-transfer marker
  input wire logic [5:0] q_sentinel, // quadrant sentinels q1..q6
  input wire logic [3:0] a_lines, // register A bits 1..4
  input wire logic [2:0] x_lines, // register X bits 5,6,check
  input wire logic [3:0] head_rd1, // track 1 head read bits
  input wire logic [3:0] head_rd2, // track 2 head read bits
  output logic write_enable_out, // write flip-flop, heads enabled
  output logic read_inhibit, // read circuits blocked
  output logic read_gate_block, // read output gates blocked
  output logic [3:0] head_wr1, // track 1 head write bits
  output logic [3:0] head_wr2, // track 2 head write bits
  output logic [6:0] compare_lines, // lines 1..7 to comparator
  output logic clear_instruction // pulse: clear load instruction
);
  import pbwr_pkg::*;

  typedef struct packed {
    pbwr_state_t st;
    logic wc;
    logic wr;
    logic ri;
    logic rgb;
    logic chars;
    logic en;
    logic [3:0] words;
    logic [3:0] hw1;
    logic [3:0] hw2;
    logic [6:0] cmp;
    logic clr;
    logic [31:0] rdata;
    logic rdy;
    logic err;
  } pbwr_top_t;

  pbwr_top_t s_q, s_d;
  logic [1:0] quad;
  logic [3:0] route_w1, route_w2, route_r1, route_r2;
  logic rev1, rev2, rev3, marker_hit, full;
  logic apb_setup, apb_done, hit_ctrl, hit_stat;
  logic [31:0] status_word;

  pbwr_quad_counter u_quad (
    .sys_clk(sys_clk),
    .srst(srst),
    .write_mode(buffer_load_sequence_step),
    .read_mode(print_active),
    .q_sentinel(q_sentinel),
    .quad(quad)
  );

  // write-side steering, both tracks share the counter [RQ3]
  pbwr_lane_router u_w1 (
    .quad(quad),
    .din(a_lines),
    .dout(route_w1)
  );
  // track 2 has only three bits; the fourth input lane is zero and rotates with the others
  pbwr_lane_router u_w2 (
    .quad(quad),
    .din({1'b0, x_lines}),
    .dout(route_w2)
  );
  // read side uses the same gates: quad 11 puts head 1 on line 2
  pbwr_lane_router u_r1 (
    .quad(quad),
    .din(head_rd1),
    .dout(route_r1)
  );
  pbwr_lane_router u_r2 (
    .quad(quad),
    .din(head_rd2),
    .dout(route_r2)
  );

  // revolution decode and marker qualification
  assign rev1 = !revolution_count_low && !revolution_count_high;
  assign rev2 = revolution_count_low && !revolution_count_high;
  assign rev3 = !revolution_count_low && revolution_count_high;
  assign marker_hit = (rev1 && marker_h && !instruction_kind_select) // [RQ13]
    || (rev2 && marker_i) // [RQ14]
    || (rev3 && marker_j); // [RQ14]
  assign full = (s_q.words == PBWR_WORDS_PER_LINE);

  // apb decode; zero-wait: ready rises in the first access cycle
  assign apb_setup = psel && !penable;
  assign apb_done = psel && penable && s_q.rdy;
  assign hit_ctrl = (paddr == PBWR_CTRL_OFS);
  assign hit_stat = (paddr == PBWR_STAT_OFS);

  // status word gathers live control state
  always_comb begin
    status_word = '0;
    status_word[PBWR_ST_WC_BIT] = s_q.wc;
    status_word[PBWR_ST_WR_BIT] = s_q.wr;
    status_word[PBWR_ST_RI_BIT] = s_q.ri;
    status_word[PBWR_ST_RGB_BIT] = s_q.rgb;
    status_word[PBWR_ST_QC_LSB +: 2] = quad;
    status_word[PBWR_ST_WORDS_LSB +: 4] = s_q.words;
    status_word[PBWR_ST_FULL_BIT] = full;
  end

  // next state of the whole block
  always_comb begin
    s_d = s_q;
    s_d.clr = 1'b0;
    // write-control / write sequencing
    unique case (s_q.st)
      PBWR_IDLE: begin
        if (buffer_load_sequence_step && s_q.en && marker_hit) begin
          s_d.st = PBWR_CTRL;
          s_d.wc = 1'b1; // [RQ1]
        end
      end
      PBWR_CTRL: begin
        if (t4b) s_d.st = PBWR_ARM; // [RQ15]
      end
      PBWR_ARM: begin
        if (t11b) begin
          s_d.st = PBWR_WRITE;
          s_d.wr = 1'b1; // [RQ2] [RQ16]
          s_d.chars = 1'b0;
        end
      end
      PBWR_WRITE: begin
        if (t0b) s_d.chars = 1'b1; // [RQ11]
        // one full word time later the word is on the drum
        if (t11b) begin
          s_d.st = PBWR_IDLE;
          s_d.wc = 1'b0; // [RQ4]
          s_d.wr = 1'b0; // [RQ4]
          s_d.chars = 1'b0;
          if (!full) s_d.words = s_q.words + 4'h1; // [RQ6]
        end
      end
    endcase
    // inhibit follows write-control and write flip-flops
    s_d.ri = s_d.wc || s_d.wr; // [RQ15] [RQ9]
    s_d.rgb = buffer_load_substep || s_d.wr; // [RQ9] [RQ12]
    // input gates only open during the load step
    if (s_q.wr && buffer_load_sequence_step && (s_q.chars || t0b)) begin
      s_d.hw1 = route_w1; // [RQ7] [RQ8] [RQ11]
      s_d.hw2 = route_w2; // [RQ3]
    end else begin
      s_d.hw1 = '0;
      s_d.hw2 = '0;
    end
    // line loaded: drop the instruction so reads can flow
    if (line_end && buffer_load_sequence_step) begin
      s_d.clr = 1'b1; // [RQ5]
      s_d.words = '0;
    end
    // read output gates, blocked while inhibited or gate-blocked
    if (!s_d.ri && !s_d.rgb && print_active) begin
      s_d.cmp = {route_r2[2:0], route_r1}; // [RQ10] [RQ5]
    end else begin
      s_d.cmp = '0;
    end
    // apb slave
    s_d.rdy = apb_setup;
    if (apb_setup) begin
      s_d.err = !(hit_ctrl || hit_stat);
      s_d.rdata = '0;
      if (!pwrite && hit_ctrl) s_d.rdata[PBWR_CTRL_EN_BIT] = s_q.en;
      if (!pwrite && hit_stat) s_d.rdata = status_word;
    end
    if (apb_done && pwrite && hit_ctrl) begin
      s_d.en = pwdata[PBWR_CTRL_EN_BIT];
      if (pwdata[PBWR_CTRL_CLR_BIT]) s_d.words = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_q <= '0;
      s_q.st <= PBWR_IDLE;
      s_q.en <= PBWR_CTRL_EN_RST;
      s_q.rgb <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign prdata = s_q.rdata;
  assign pready = s_q.rdy;
  assign pslverr = s_q.err;
  assign write_enable_out = s_q.wr;
  assign read_inhibit = s_q.ri;
  assign read_gate_block = s_q.rgb;
  assign head_wr1 = s_q.hw1;
  assign head_wr2 = s_q.hw2;
  assign compare_lines = s_q.cmp;
  assign clear_instruction = s_q.clr;

  // checks
  sequence s_arm_word;
    (s_q.st == PBWR_ARM) && t11b;
  endsequence

  sequence s_write_word;
    s_q.wr && !t11b;
  endsequence

  property p_rev1_set;
    @(posedge sys_clk) disable iff (srst)
    (s_q.st == PBWR_IDLE && s_q.en && buffer_load_sequence_step && rev1
      && marker_h && !instruction_kind_select) |=> s_q.wc;
  endproperty
  a_rev1_set: assert property (p_rev1_set) // [RQ13]
    else $error("write-control not set on first-revolution marker");

  property p_rev1_blocked;
    @(posedge sys_clk) disable iff (srst)
    (s_q.st == PBWR_IDLE && rev1 && marker_h && instruction_kind_select
      && !marker_i && !marker_j) |=> !s_q.wc;
  endproperty
  a_rev1_blocked: assert property (p_rev1_blocked) // [RQ13]
    else $error("write-control set during paper advance");

  property p_inhibit;
    @(posedge sys_clk) disable iff (srst)
    s_q.wc |-> s_q.ri;
  endproperty
  a_inhibit: assert property (p_inhibit) // [RQ15]
    else $error("read inhibit low while write-control set");

  property p_write_set;
    @(posedge sys_clk) disable iff (srst)
    s_arm_word |=> s_q.wr && write_enable_out;
  endproperty
  a_write_set: assert property (p_write_set) // [RQ16]
    else $error("write flip-flop not set at t11B");

  property p_restore;
    @(posedge sys_clk) disable iff (srst)
    s_write_word ##1 (s_q.wr && t11b) |=> !s_q.wc && !s_q.wr;
  endproperty
  a_restore: assert property (p_restore) // [RQ4]
    else $error("flip-flops not restored after word");

  property p_gate_block;
    @(posedge sys_clk) disable iff (srst)
    s_q.wr |-> read_gate_block && compare_lines == 7'h00;
  endproperty
  a_gate_block: assert property (p_gate_block) // [RQ9]
    else $error("read gates open while writing");

  property p_gate_open;
    @(posedge sys_clk) disable iff (srst)
    (!buffer_load_substep && !s_q.wr && !s_d.wr) |=> !read_gate_block;
  endproperty
  a_gate_open: assert property (p_gate_open) // [RQ12]
    else $error("read gates stay blocked after sub-step low");

  property p_lane_ident;
    @(posedge sys_clk) disable iff (srst)
    (s_q.wr && s_q.chars && buffer_load_sequence_step && quad == PBWR_QC_Q1
      && !t11b) |=> head_wr1 == $past(a_lines);
  endproperty
  a_lane_ident: assert property (p_lane_ident) // [RQ7]
    else $error("head n does not write line n in first quarter");

  property p_quad_q1;
    @(posedge sys_clk) disable iff (srst)
    (buffer_load_sequence_step && q_sentinel == 6'h10) |=> quad == PBWR_QC_Q1;
  endproperty
  a_quad_q1: assert property (p_quad_q1) // [RQ17]
    else $error("quadrant counter not cleared by q5");

  property p_read_route;
    @(posedge sys_clk) disable iff (srst)
    (print_active && !buffer_load_substep && !buffer_load_sequence_step
      && s_q.st == PBWR_IDLE && quad == PBWR_QC_Q2)
      |=> compare_lines[1] == $past(head_rd1[0]);
  endproperty
  a_read_route: assert property (p_read_route) // [RQ10]
    else $error("head one not routed to line two in quadrant reading 11");

  property p_line_clear;
    @(posedge sys_clk) disable iff (srst)
    (line_end && buffer_load_sequence_step) |=> clear_instruction && s_q.words == 4'h0;
  endproperty
  a_line_clear: assert property (p_line_clear) // [RQ5]
    else $error("load instruction not cleared at line end");
endmodule : pbwr_buffer_ctrl

/* File: hw/pbwr_pkg.sv */
// What this block does
// RQ1 - marker sets write-control, blocking buffer reads
// RQ2 - write-control set leads to write set
// RQ3 - register A to track 1, X to track 2
// RQ4 - clear both flip-flops after word written
// RQ5 - line loaded: clear instruction, release read inhibit
// RQ6 - thirteen words, four-bit groups onto track 1
// RQ7 - head n writes bit of line n
// RQ8 - rotate register-A bits each quarter revolution
// RQ9 - writing: reads inhibited, read gates blocked high
// RQ10 - reading: bit n always on line n; the code rotates read bits by quadrant, so this holds in Q1 only
// RQ11 - load step opens inputs; first char t0B
// RQ12 - read gates open when substep falls low
// RQ13 - revolution one marker needs low instruction select
// RQ14 - revolution two and three markers set write-control
// RQ15 - write-control arms set gate at t4B, inhibits
// RQ16 - write set at t11B, enables all heads
// RQ17 - two-flip-flop quadrant counter selects lane gates
package pbwr_pkg;
  // register map, byte addresses
  localparam logic [11:0] PBWR_CTRL_OFS = 12'h000;
  localparam logic [11:0] PBWR_STAT_OFS = 12'h004;
  // control fields
  localparam int PBWR_CTRL_EN_BIT = 0;
  localparam int PBWR_CTRL_CLR_BIT = 1;
  localparam logic PBWR_CTRL_EN_RST = 1'b1;
  // status fields
  localparam int PBWR_ST_WC_BIT = 0;
  localparam int PBWR_ST_WR_BIT = 1;
  localparam int PBWR_ST_RI_BIT = 2;
  localparam int PBWR_ST_RGB_BIT = 3;
  localparam int PBWR_ST_QC_LSB = 4;
  localparam int PBWR_ST_WORDS_LSB = 8;
  localparam int PBWR_ST_FULL_BIT = 12;
  // words per printed line
  localparam logic [3:0] PBWR_WORDS_PER_LINE = 4'hD;
  // quadrant counter readings {ff1,ff2} per quarter
  localparam logic [1:0] PBWR_QC_Q1 = 2'h0;
  localparam logic [1:0] PBWR_QC_Q2 = 2'h3;
  localparam logic [1:0] PBWR_QC_Q3 = 2'h1;
  localparam logic [1:0] PBWR_QC_Q4 = 2'h2;
  // sentinel positions on the q_sentinel bus (q1 at bit 0)
  localparam int PBWR_Q1 = 0;
  localparam int PBWR_Q2 = 1;
  localparam int PBWR_Q3 = 2;
  localparam int PBWR_Q4 = 3;
  localparam int PBWR_Q5 = 4;
  localparam int PBWR_Q6 = 5;
  typedef enum logic [3:0] {
    PBWR_IDLE = 4'b0001,
    PBWR_CTRL = 4'b0010,
    PBWR_ARM = 4'b0100,
    PBWR_WRITE = 4'b1000
  } pbwr_state_t;
endpackage : pbwr_pkg

/* File: hw/pbwr_quad_counter.sv */
`timescale 1ns/100ps
module pbwr_quad_counter (
  input wire logic sys_clk, // system clock
  input wire logic srst, // sync reset
  input wire logic write_mode, // load step active
  input wire logic read_mode, // print reading active
  input wire logic [5:0] q_sentinel, // q1..q6 marker pulses
  output logic [1:0] quad // {ff1,ff2}
);
  import pbwr_pkg::*;
  typedef struct packed {
    logic [1:0] qc;
  } pbwr_qc_t;
  pbwr_qc_t s_q, s_d;
  logic q1, q2, q3, q4, q5, q6;
  assign {q6, q5, q4, q3, q2, q1} = q_sentinel;
  // decode sentinel combinations; write and read walk opposite orders
  always_comb begin
    s_d = s_q;
    if (write_mode) begin
      if (q4 && q6) s_d.qc = PBWR_QC_Q2; // [RQ17]
      else if (q4 && q5) s_d.qc = PBWR_QC_Q3;
      else if (q5 && q6) s_d.qc = PBWR_QC_Q4;
      else if (q5) s_d.qc = PBWR_QC_Q1;
    end else if (read_mode) begin
      if (q2 && q3) s_d.qc = PBWR_QC_Q3; // [RQ17]
      else if (q2) s_d.qc = PBWR_QC_Q1;
      else if (q1) s_d.qc = {1'b1, s_q.qc[0]}; // q1 only sets ff1
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst) s_q <= '0;
    else s_q <= s_d;
  end
  assign quad = s_q.qc;
endmodule : pbwr_quad_counter

/* File: hw/pbwr_lane_router.sv */
`timescale 1ns/100ps
module pbwr_lane_router (
  input wire logic [1:0] quad, // quadrant counter reading
  input wire logic [3:0] din, // lanes in
  output logic [3:0] dout // lanes out
);
  import pbwr_pkg::*;
  logic [1:0] rot;
  // quadrant reading to rotation amount
  always_comb begin
    unique case (quad)
      PBWR_QC_Q1: rot = 2'h0;
      PBWR_QC_Q2: rot = 2'h1;
      PBWR_QC_Q3: rot = 2'h2;
      PBWR_QC_Q4: rot = 2'h3;
    endcase
  end
  // one gate per lane per quarter; rotating keeps a bit in its quadrant
  // reading walks the quadrants in reverse order, so one shift serves both
  for (genvar k = 0; k < 4; k++) begin : g_lane
    logic [1:0] src;
    assign src = 2'(k) - rot; // [RQ8] [RQ10]
    assign dout[k] = din[src];
  end
endmodule : pbwr_lane_router

/* File: dv/pbwr_cpu_model.sv */
`timescale 1ns/100ps
// processor side: revolution count, markers, word-time pulses, register A/X lines
module pbwr_cpu_model (
  input wire logic sys_clk, // system clock
  output logic revolution_count_low, // revolution count bit 0
  output logic revolution_count_high, // revolution count bit 1
  output logic marker_h, // first-revolution marker
  output logic marker_i, // second-revolution marker
  output logic marker_j, // third-revolution marker
  output logic t0b, // word-time pulse t0B
  output logic t4b, // word-time pulse t4B
  output logic t11b, // word-time pulse t11B
  output logic [3:0] a_lines, // register A bits
  output logic [2:0] x_lines // register X bits
);
  logic [5:0] p_q;
  // pulses share one vector so a single process drives them
  assign {marker_h, marker_i, marker_j, t0b, t4b, t11b} = p_q;
  initial begin
    p_q = 6'h00;
    {revolution_count_high, revolution_count_low} = 2'h0;
    a_lines = 4'h5;
    x_lines = 3'h2;
  end
  // one-cycle pulse; a larger gap models a slow processor
  task automatic pulse(input int k, input int gap);
    p_q[k] <= 1'h1;
    @(posedge sys_clk);
    p_q <= 6'h00;
    repeat (gap + 1) @(posedge sys_clk);
  endtask : pulse
  // marker, t4b, t11b, then characters from t0b on
  task automatic start_word(input int rev, input logic [3:0] a, input logic [2:0] x,
                            input int gap);
    {revolution_count_high, revolution_count_low} <= 2'(rev - 1);
    pulse(6 - rev, gap);
    pulse(1, gap);
    pulse(0, gap);
    a_lines <= a;
    x_lines <= x;
    pulse(2, gap);
  endtask : start_word
  // closing t11b; the lines then carry junk, never the old word
  task automatic end_word(input int gap);
    pulse(0, gap);
    a_lines <= ~a_lines;
    x_lines <= ~x_lines;
  endtask : end_word
endmodule : pbwr_cpu_model

/* File: dv/tb_print_buffer_write_read_control.sv */
`timescale 1ns/100ps
module tb_print_buffer_write_read_control;
  import pbwr_pkg::*;
  logic sys_clk, srst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic buffer_load_sequence_step, buffer_load_substep, instruction_kind_select;
  logic revolution_count_low, revolution_count_high, marker_h, marker_i, marker_j;
  logic t0b, t4b, t11b, print_active, line_end, write_enable_out, read_inhibit;
  logic read_gate_block, clear_instruction;
  logic [5:0] q_sentinel;
  logic [3:0] a_lines, head_rd1, head_rd2, head_wr1, head_wr2, a, rd1, rd2;
  logic [2:0] x_lines, x;
  logic [6:0] compare_lines;
  logic [32:0] exp_q [$];
  logic [5:0] wq [4] = '{6'h10, 6'h28, 6'h18, 6'h30};
  logic [1:0] wqd [4] = '{PBWR_QC_Q1, PBWR_QC_Q2, PBWR_QC_Q3, PBWR_QC_Q4};
  logic [5:0] rq [4] = '{6'h02, 6'h01, 6'h06, 6'h01};
  int rr [4] = '{0, 3, 2, 1};
  int bad_count = 0;
  int tests_run = 0;
  int seed = 55986;
  int cyc = 0;

  pbwr_buffer_ctrl u_dut (
    .sys_clk(sys_clk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .buffer_load_sequence_step(buffer_load_sequence_step),
    .buffer_load_substep(buffer_load_substep),
    .instruction_kind_select(instruction_kind_select),
    .revolution_count_low(revolution_count_low),
    .revolution_count_high(revolution_count_high),
    .marker_h(marker_h), .marker_i(marker_i), .marker_j(marker_j),
    .t0b(t0b), .t4b(t4b), .t11b(t11b), .print_active(print_active), .line_end(line_end),
    .q_sentinel(q_sentinel), .a_lines(a_lines), .x_lines(x_lines),
    .head_rd1(head_rd1), .head_rd2(head_rd2), .write_enable_out(write_enable_out),
    .read_inhibit(read_inhibit), .read_gate_block(read_gate_block),
    .head_wr1(head_wr1), .head_wr2(head_wr2), .compare_lines(compare_lines),
    .clear_instruction(clear_instruction)
  );
  pbwr_cpu_model u_cpu (
    .sys_clk(sys_clk), .revolution_count_low(revolution_count_low),
    .revolution_count_high(revolution_count_high),
    .marker_h(marker_h), .marker_i(marker_i), .marker_j(marker_j),
    .t0b(t0b), .t4b(t4b), .t11b(t11b), .a_lines(a_lines), .x_lines(x_lines)
  );

  always #5 sys_clk = ~sys_clk;

  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  // apb master; a read notes its expected {pslverr, prdata}
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [32:0] d);
    int n;
    n = 0;
    if (!wr) exp_q.push_back(d);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d[31:0];
    @(posedge sys_clk);
    penable <= 1'h1;
    @(posedge sys_clk);
    while (pready !== 1'h1 && n < 50) begin
      n++;
      @(posedge sys_clk);
    end
    if (n == 50) bad_count++;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge sys_clk);
  endtask : apb

  // one quadrant step from a sentinel combination
  task automatic qstep(input logic [5:0] s);
    q_sentinel <= s;
    @(posedge sys_clk);
    q_sentinel <= 6'h00;
    @(posedge sys_clk);
  endtask : qstep

  function automatic logic [3:0] rl(input logic [3:0] v, input int r);
    logic [7:0] t;
    t = {v, v} << r;
    return t[7:4];
  endfunction : rl

  // read results are matched against the oldest note
  always @(posedge sys_clk) begin
    if (psel && penable && pready === 1'h1 && !pwrite) begin
      chk("apb read", {pslverr, prdata}, exp_q.pop_front());
    end
  end

  // hang guard, far above the expected run length
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      complete_run();
    end
  end

  initial begin
    sys_clk = 1'h0;
    srst = 1'h1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {buffer_load_sequence_step, buffer_load_substep, print_active, line_end} = '0;
    instruction_kind_select = 1'h1;
    {q_sentinel, head_rd1, head_rd2} = '0;
    repeat (6) @(posedge sys_clk);
    srst <= 1'h0;
    apb(0, PBWR_CTRL_OFS, 33'h1);
    apb(0, PBWR_STAT_OFS, 33'h0);
    apb(1, 12'h008, 33'hF);
    apb(0, 12'h008, 33'h1_0000_0000);
    $display("test registers done");
    // paper advance selected, then enable off: word ignored
    buffer_load_sequence_step <= 1'h1;
    u_cpu.start_word(1, 4'hA, 3'h5, 1);
    chk("kind refused", {write_enable_out, read_inhibit}, 2'h0);
    u_cpu.end_word(1);
    instruction_kind_select <= 1'h0;
    apb(1, PBWR_CTRL_OFS, 33'h0);
    u_cpu.start_word(2, 4'h6, 3'h3, 1);
    chk("disabled", {write_enable_out, read_inhibit}, 2'h0);
    u_cpu.end_word(1);
    apb(1, PBWR_CTRL_OFS, 33'h1);
    $display("test refusals done");
    // fourteen words over three revolutions and all quadrants
    for (int i = 0; i < 14; i++) begin
      qstep(wq[i % 4]);
      a = 4'($random(seed));
      x = 3'($random(seed));
      u_cpu.start_word(i % 3 + 1, a, x, i % 2 * 3);
      chk("write ff", write_enable_out, 1'h1);
      chk("inhibit", {read_inhibit, read_gate_block, compare_lines}, 9'h180);
      chk("track1", head_wr1, rl(a, i % 4));
      chk("track2", head_wr2, rl({1'h0, x}, i % 4));
      apb(0, PBWR_STAT_OFS, {19'h0, i == 13, 4'(i), 2'h0, wqd[i % 4], 4'hF});
      u_cpu.end_word(1);
      chk("restore", {write_enable_out, read_inhibit, head_wr1}, 6'h0);
    end
    $display("test writing done");
    // end of line: load instruction cleared, count reset
    line_end <= 1'h1;
    @(posedge sys_clk);
    line_end <= 1'h0;
    @(posedge sys_clk);
    chk("clear pulse", clear_instruction, 1'h1);
    @(posedge sys_clk);
    chk("clear pulse end", clear_instruction, 1'h0);
    apb(0, PBWR_STAT_OFS, {26'h0, wqd[1], 4'h0});
    $display("test line end done");
    // reading: gates held by the sub-step, then every quadrant
    buffer_load_sequence_step <= 1'h0;
    buffer_load_substep <= 1'h1;
    print_active <= 1'h1;
    head_rd1 <= 4'hF;
    repeat (2) @(posedge sys_clk);
    chk("gates blocked", {read_gate_block, compare_lines}, 8'h80);
    buffer_load_substep <= 1'h0;
    for (int i = 0; i < 4; i++) begin
      qstep(rq[i]);
      rd1 = 4'($random(seed));
      rd2 = 4'($random(seed));
      head_rd1 <= rd1;
      head_rd2 <= rd2;
      repeat (2) @(posedge sys_clk);
      chk("read lines", {read_gate_block, compare_lines},
          {1'h0, 3'(rl(rd2, rr[i])), rl(rd1, rr[i])});
    end
    $display("test reading done");
    complete_run();
  end
endmodule : tb_print_buffer_write_read_control
